// ### hdl/sgc_cache_ctrl.sv
// sgc_cache_ctrl: segment tag table, hit/miss decision, write caching and read-ahead
// assumes the media path answers each media request with one done pulse and error flag
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps

module sgc_cache_ctrl #(
  parameter int NUM_SEG = 8,
  parameter int SEG_BLOCKS = 256,
  parameter int PF_BLOCKS = 64,
  parameter int BUF_TOTAL_KB = sgc_pkg::BUF_TOTAL_KB,
  parameter int BUF_CACHE_KB = sgc_pkg::BUF_CACHE_KB
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // host command port
  input wire sgc_pkg::sgc_req_s host_req_i,
  output logic host_ready_o,
  output sgc_pkg::sgc_resp_s host_resp_o,
  // media path
  output sgc_pkg::sgc_media_s media_req_o,
  input wire logic media_done_i,
  input wire logic media_err_i
);
  localparam int SW = $clog2(NUM_SEG);

  // ==========
  // local names for package types and states
  typedef sgc_pkg::sgc_req_s sgc_req_s;
  typedef sgc_pkg::sgc_resp_s sgc_resp_s;
  typedef sgc_pkg::sgc_media_s sgc_media_s;
  typedef sgc_pkg::sgc_state_e sgc_state_e;
  localparam sgc_state_e SGC_IDLE = sgc_pkg::SGC_IDLE;
  localparam sgc_state_e SGC_LOOKUP = sgc_pkg::SGC_LOOKUP;
  localparam sgc_state_e SGC_MEDIA = sgc_pkg::SGC_MEDIA;
  localparam sgc_state_e SGC_XFER = sgc_pkg::SGC_XFER;
  localparam sgc_state_e SGC_FLUSH = sgc_pkg::SGC_FLUSH;
  localparam sgc_state_e SGC_DONE = sgc_pkg::SGC_DONE;

  // ==========
  // module state

  typedef struct packed {
    logic [NUM_SEG-1:0] valid;
    logic [NUM_SEG-1:0] dirty;
    logic [NUM_SEG-1:0] prefetched;
    logic [NUM_SEG-1:0][31:0] base;
    logic [NUM_SEG-1:0][15:0] len;
    logic [SW-1:0] victim;
    logic [SW-1:0] cur;
    logic [3:0] ctrl;
    logic deferred;
    logic fixed_err;
    logic [1:0] pf_score;
    logic [15:0] cache_hits;
    logic [15:0] pf_hits;
    sgc_req_s req;
    sgc_resp_s resp;
    sgc_media_s media;
    logic media_wait;
    logic pf_phase;
    logic [31:0] rdata;
    sgc_state_e state;
  } sgc_st_s;

  sgc_st_s st_q, st_d;

  // ==========
  // does segment s hold every block of the range
  function automatic logic covers(input logic [31:0] b, input logic [15:0] l,
                                  input logic [31:0] lba, input logic [15:0] cnt);
    covers = (lba >= b) && ({1'b0, lba} + {17'h0, cnt} <= {1'b0, b} + {17'h0, l});
  endfunction

  function automatic logic overlaps(input logic [31:0] b, input logic [15:0] l,
                                    input logic [31:0] lba, input logic [15:0] cnt);
    overlaps = ({1'b0, lba} < {1'b0, b} + {17'h0, l}) &&
               ({1'b0, b} < {1'b0, lba} + {17'h0, cnt});
  endfunction

  // ==========
  // tag compare per segment
  logic [NUM_SEG-1:0] hit_vec, ovl_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_tag
      assign hit_vec[g] = st_q.valid[g] &&
        covers(st_q.base[g], st_q.len[g], st_q.req.lba, st_q.req.count);
      assign ovl_vec[g] = st_q.valid[g] &&
        overlaps(st_q.base[g], st_q.len[g], st_q.req.lba, st_q.req.count);
    end
  endgenerate

  // ==========
  // lowest matching segment and lowest dirty segment
  logic [SW-1:0] hit_idx;
  always_comb begin
    hit_idx = '0;
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = SW'(i);
      end
    end
  end

  logic [SW-1:0] dirty_idx;
  always_comb begin
    dirty_idx = '0;
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if (st_q.dirty[i]) begin
        dirty_idx = SW'(i);
      end
    end
  end

  // ==========
  // control bits
  logic rd_cache_off, wr_cache_on, ahead_off;
  assign rd_cache_off = st_q.ctrl[sgc_pkg::CTRL_RD_CACHE_OFF];
  assign wr_cache_on = st_q.ctrl[sgc_pkg::CTRL_WR_CACHE_ON];
  assign ahead_off = st_q.ctrl[sgc_pkg::CTRL_AHEAD_OFF];

  // ==========
  // next state

  always_comb begin
    st_d = st_q;
    st_d.resp.valid = 1'b0;
    st_d.media.valid = 1'b0;
    // registers
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        sgc_pkg::REG_CTRL: begin
          st_d.ctrl = reg_wdata_i[3:0];
        end
        sgc_pkg::REG_SEG_SIZE: begin
          if (st_q.ctrl[sgc_pkg::CTRL_FIXED_CHECK]) begin
            st_d.fixed_err = 1'b1;
          end
        end
        sgc_pkg::REG_PF_LIMITS: begin
          st_d.rdata = st_q.rdata;
        end
        sgc_pkg::REG_STATUS: begin
          if (reg_wdata_i[sgc_pkg::ST_DEFERRED]) begin
            st_d.deferred = 1'b0;
          end
          if (reg_wdata_i[sgc_pkg::ST_FIXED_ERR]) begin
            st_d.fixed_err = 1'b0;
          end
        end
        sgc_pkg::REG_SEG_CMD: begin
          // drop a clean segment before any later lookup; a write lookup in the same cycle overrides it while read caching is on
          if (!st_q.dirty[reg_wdata_i[SW-1:0]]) begin
            st_d.valid[reg_wdata_i[SW-1:0]] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    st_d.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sgc_pkg::REG_CTRL: st_d.rdata = {28'h0, st_q.ctrl};
        sgc_pkg::REG_STATUS: st_d.rdata = {27'h0, |st_q.dirty, st_q.pf_score >= sgc_pkg::PF_SCORE_ON,
          st_q.fixed_err, st_q.deferred, st_q.state != SGC_IDLE};
        sgc_pkg::REG_SEG_SIZE: st_d.rdata = {16'h0, sgc_pkg::SEG_SIZE_REPORT};
        sgc_pkg::REG_HITS: st_d.rdata = {st_q.pf_hits, st_q.cache_hits};
        default: st_d.rdata = '0;
      endcase
    end
    // command engine
    unique case (st_q.state)
      SGC_IDLE: begin
        if (host_req_i.valid) begin
          st_d.req = host_req_i;
          st_d.state = SGC_LOOKUP;
        end
      end
      SGC_LOOKUP: begin
        st_d.resp.seg = 8'(st_q.victim);
        unique case (st_q.req.cmd)
          sgc_pkg::SGC_CMD_READ: begin
            if (|hit_vec && (!rd_cache_off || st_q.prefetched[hit_idx])) begin
              // full hit: no medium access
              st_d.resp.valid = 1'b1;
              st_d.resp.good = 1'b1;
              st_d.resp.seg = 8'(hit_idx);
              if (st_q.prefetched[hit_idx]) begin
                st_d.resp.result = sgc_pkg::SGC_RES_PF_HIT;
                st_d.pf_hits = st_q.pf_hits + 16'h1;
                if (st_q.pf_score != sgc_pkg::PF_SCORE_MAX) begin
                  st_d.pf_score = st_q.pf_score + 2'h1;
                end
              end else begin
                st_d.resp.result = sgc_pkg::SGC_RES_CACHE_HIT;
                st_d.cache_hits = st_q.cache_hits + 16'h1;
              end
              st_d.state = SGC_IDLE;
            end else if (st_q.dirty[st_q.victim]) begin
              st_d.state = SGC_FLUSH;
            end else begin
              // miss: reuse victim segment for staging
              st_d.valid[st_q.victim] = 1'b0;
              st_d.cur = st_q.victim;
              st_d.media = '{1'b1, 1'b0, st_q.req.lba, st_q.req.count, 8'(st_q.victim)};
              st_d.pf_phase = 1'b0;
              // a still-valid read-ahead segment being reused counts against prefetch, hit or not;
              // otherwise the score creeps back so prefetch can resume
              if (st_q.valid[st_q.victim] && st_q.prefetched[st_q.victim]) begin
                if (st_q.pf_score != '0) begin
                  st_d.pf_score = st_q.pf_score - 2'h1;
                end
              end else if (st_q.pf_score < sgc_pkg::PF_SCORE_ON) begin
                st_d.pf_score = st_q.pf_score + 2'h1;
              end
              st_d.state = SGC_MEDIA;
            end
          end
          sgc_pkg::SGC_CMD_WRITE: begin
            if (st_q.dirty[st_q.victim]) begin
              st_d.state = SGC_FLUSH;
            end else begin
              if (!rd_cache_off) begin
                st_d.valid = st_q.valid & ~(ovl_vec & ~st_q.dirty);
              end
              st_d.cur = st_q.victim;
              st_d.valid[st_q.victim] = 1'b1;
              st_d.prefetched[st_q.victim] = 1'b0;
              st_d.base[st_q.victim] = st_q.req.lba;
              st_d.len[st_q.victim] = st_q.req.count;
              st_d.victim = st_q.victim + SW'(1);
              if (wr_cache_on) begin
                st_d.dirty[st_q.victim] = 1'b1;
                st_d.resp = '{1'b1, 1'b1, sgc_pkg::SGC_RES_MISS, 8'(st_q.victim)};
                st_d.state = SGC_IDLE;
              end else begin
                st_d.media = '{1'b1, 1'b1, st_q.req.lba, st_q.req.count, 8'(st_q.victim)};
                st_d.state = SGC_MEDIA;
              end
            end
          end
          default: begin
            st_d.state = SGC_FLUSH;
          end
        endcase
      end
      SGC_FLUSH: begin
        if (!st_q.media_wait) begin
          if (|st_q.dirty) begin
            st_d.media = '{1'b1, 1'b1, st_q.base[dirty_idx], st_q.len[dirty_idx],
                           8'(dirty_idx)};
            st_d.cur = dirty_idx;
            st_d.media_wait = 1'b1;
          end else if (st_q.req.cmd == sgc_pkg::SGC_CMD_SYNC) begin
            st_d.resp = '{1'b1, !st_q.deferred, sgc_pkg::SGC_RES_MISS, 8'h0};
            st_d.state = SGC_IDLE;
          end else begin
            st_d.state = SGC_LOOKUP;
          end
        end else if (media_done_i) begin
          st_d.media_wait = 1'b0;
          st_d.dirty[st_q.cur] = 1'b0;
          if (media_err_i) begin
            st_d.deferred = 1'b1;
            st_d.valid[st_q.cur] = 1'b0;
          end
        end
      end
      SGC_MEDIA: begin
        if (media_done_i) begin
          if (st_q.pf_phase) begin
            st_d.valid[st_q.cur] = !media_err_i;
            st_d.prefetched[st_q.cur] = 1'b1;
            st_d.base[st_q.cur] = st_q.req.lba + {16'h0, st_q.req.count};
            st_d.len[st_q.cur] = 16'(PF_BLOCKS);
            st_d.victim = st_q.cur + SW'(1);
            st_d.state = SGC_IDLE;
          end else begin
            st_d.resp = '{1'b1, !media_err_i, sgc_pkg::SGC_RES_MISS, 8'(st_q.cur)};
            st_d.valid[st_q.cur] = !media_err_i && !(rd_cache_off && !st_q.media.write);
            st_d.prefetched[st_q.cur] = 1'b0;
            st_d.base[st_q.cur] = st_q.req.lba;
            st_d.len[st_q.cur] = st_q.req.count;
            st_d.victim = st_q.cur + SW'(1);
            st_d.state = SGC_XFER;
          end
        end
      end
      SGC_XFER: begin
        // read-ahead after a read miss when judged useful
        if (st_q.req.cmd == sgc_pkg::SGC_CMD_READ && !ahead_off &&
            st_q.pf_score >= sgc_pkg::PF_SCORE_ON && !st_q.dirty[st_q.victim]) begin
          st_d.valid[st_q.victim] = 1'b0;
          st_d.cur = st_q.victim;
          st_d.pf_phase = 1'b1;
          st_d.media = '{1'b1, 1'b0, st_q.req.lba + {16'h0, st_q.req.count},
                         16'(PF_BLOCKS), 8'(st_q.victim)};
          st_d.state = SGC_MEDIA;
        end else begin
          st_d.state = SGC_DONE;
        end
      end
      SGC_DONE: begin
        st_d.state = SGC_IDLE;
      end
      default: begin
        st_d.state = SGC_IDLE;
      end
    endcase
  end

  // ==========
  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.ctrl <= sgc_pkg::CTRL_RESET;
      st_q.pf_score <= sgc_pkg::PF_SCORE_INIT;
      st_q.state <= SGC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========
  // outputs
  assign host_ready_o = (st_q.state == SGC_IDLE);
  assign host_resp_o = st_q.resp;
  assign media_req_o = st_q.media;
  assign reg_rdata_o = st_q.rdata;
endmodule

// ### hdl/sgc_pkg.sv
// sgc_pkg: constants, types and register map of the segmented cache controller
// assumes one core clock; registers reached over a plain strobe port
package sgc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SEG_SIZE = 8'h08;
  localparam logic [7:0] REG_PF_LIMITS = 8'h0c;
  localparam logic [7:0] REG_HITS = 8'h10;
  localparam logic [7:0] REG_SEG_CMD = 8'h14;
  // control field positions
  localparam int CTRL_RD_CACHE_OFF = 0;
  localparam int CTRL_WR_CACHE_ON = 1;
  localparam int CTRL_AHEAD_OFF = 2;
  localparam int CTRL_FIXED_CHECK = 3;
  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DEFERRED = 1;
  localparam int ST_FIXED_ERR = 2;
  localparam int ST_PF_ACTIVE = 3;
  localparam int ST_DIRTY = 4;
  // reported segment size, fixed
  localparam logic [15:0] SEG_SIZE_REPORT = 16'hffff;
  // control reset value: caching on, write cache off, prefetch on, check off
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // buffer figures
  localparam int BUF_TOTAL_KB = 16384;
  localparam int BUF_CACHE_KB = 13000;
  // prefetch judgement counter
  localparam logic [1:0] PF_SCORE_INIT = 2'h2;
  localparam logic [1:0] PF_SCORE_MAX = 2'h3;
  localparam logic [1:0] PF_SCORE_ON = 2'h2;

  typedef enum logic [1:0] {SGC_CMD_READ, SGC_CMD_WRITE, SGC_CMD_SYNC} sgc_cmd_e;
  typedef enum {SGC_IDLE, SGC_LOOKUP, SGC_MEDIA, SGC_XFER, SGC_FLUSH, SGC_DONE} sgc_state_e;
  typedef enum logic [1:0] {SGC_RES_MISS, SGC_RES_CACHE_HIT, SGC_RES_PF_HIT} sgc_res_e;

  typedef struct packed {
    logic valid;
    sgc_cmd_e cmd;
    logic [31:0] lba;
    logic [15:0] count;
  } sgc_req_s;

  typedef struct packed {
    logic valid;
    logic good;
    sgc_res_e result;
    logic [7:0] seg;
  } sgc_resp_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] lba;
    logic [15:0] count;
    logic [7:0] seg;
  } sgc_media_s;
endpackage

// ### tb/sgc_cache_ctrl_assertions.sv
// sgc_cache_ctrl_assertions: port checks of the segmented cache controller
// assumes a bind onto sgc_cache_ctrl, one clock, active-low async reset
`timescale 1ns/1ps
module sgc_cache_ctrl_assertions #(
  parameter int NUM_SEG = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // host and media
  input wire sgc_pkg::sgc_req_s host_req_i,
  input wire logic host_ready_o,
  input wire sgc_pkg::sgc_resp_s host_resp_o,
  input wire sgc_pkg::sgc_media_s media_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // checks
  chk_seg_size_fixed: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == sgc_pkg::REG_SEG_SIZE
    |-> reg_rdata_o[15:0] == 16'hffff) else $error("segment size not fixed");
  chk_hit_no_media: assert property (
    host_resp_o.valid && host_resp_o.result == sgc_pkg::SGC_RES_CACHE_HIT
    |-> !$past(media_req_o.valid) && !$past(media_req_o.valid, 2))
    else $error("cache hit used the medium");
  chk_pf_hit_no_media: assert property (
    host_resp_o.valid && host_resp_o.result == sgc_pkg::SGC_RES_PF_HIT
    |-> !$past(media_req_o.valid) && !$past(media_req_o.valid, 2))
    else $error("prefetch hit used the medium");
  chk_hit_latency: assert property (
    host_resp_o.valid && host_resp_o.result != sgc_pkg::SGC_RES_MISS
    |-> $past(host_req_i.valid && host_ready_o, 2)) else $error("hit answer late");
  chk_resp_pulse: assert property (
    host_resp_o.valid |=> !host_resp_o.valid) else $error("response not a pulse");
  chk_media_pulse: assert property (
    media_req_o.valid |=> !media_req_o.valid) else $error("media request not a pulse");
  chk_take_busy: assert property (
    host_req_i.valid && host_ready_o ##1 1'b1 |-> !host_ready_o)
    else $error("ready stayed high after take");
  chk_seg_range: assert property (
    media_req_o.valid |-> media_req_o.seg < NUM_SEG) else $error("segment out of range");
  chk_rdata_quiet: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data not quiet");
endmodule

// ### tb/sgc_media_model.sv
// sgc_media_model: media path, one done pulse per request after a delay
// assumes one-cycle request pulses; fail_i marks answers as failed
`timescale 1ns/1ps
module sgc_media_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // media request and answer
  input wire sgc_pkg::sgc_media_s media_req_i,
  input wire logic fail_i,
  output logic done_o,
  output logic err_o,
  output int req_cnt_o,
  output int pend_o
);
  int tmr;
  logic fire;
  assign fire = (pend_o > 0) && (tmr == 5);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      req_cnt_o <= 0;
      pend_o <= 0;
      tmr <= 0;
    end else begin
      done_o <= fire;
      err_o <= fire && fail_i;
      req_cnt_o <= req_cnt_o + int'(media_req_i.valid);
      pend_o <= pend_o + int'(media_req_i.valid) - int'(fire);
      tmr <= (fire || pend_o == 0) ? 0 : tmr + 1;
    end
  end
endmodule

// ### tb/sgc_cache_ctrl_bench.sv
// sgc_cache_ctrl_bench: directed tests of the segmented cache controller
// assumes the media model answers every media request
`timescale 1ns/1ps
module sgc_cache_ctrl_bench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fail = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [31:0] rd;
  sgc_pkg::sgc_req_s host_req_i = '0;
  sgc_pkg::sgc_resp_s host_resp_o;
  sgc_pkg::sgc_resp_s rsp;
  sgc_pkg::sgc_media_s media_req_o;
  logic host_ready_o;
  logic media_done_i;
  logic media_err_i;
  int req_cnt, pend, lat, nreq;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  sgc_cache_ctrl dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .host_req_i(host_req_i), .host_ready_o(host_ready_o),
    .host_resp_o(host_resp_o), .media_req_o(media_req_o), .media_done_i(media_done_i),
    .media_err_i(media_err_i));
  sgc_media_model u_media (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .media_req_i(media_req_o), .fail_i(fail), .done_o(media_done_i),
    .err_o(media_err_i), .req_cnt_o(req_cnt), .pend_o(pend));
  // ==========
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 500; i++) begin
      #1;
      if (pend == 0 && host_ready_o === 1'b1 && media_req_o.valid === 1'b0) break;
      @(posedge sys_clk_i);
    end
  endtask
  task automatic cmd(input sgc_pkg::sgc_cmd_e c, input logic [31:0] lba, input logic [15:0] n);
    int base;
    settle();
    base = req_cnt;
    @(posedge sys_clk_i);
    host_req_i <= '{1'b1, c, lba, n};
    @(posedge sys_clk_i);
    host_req_i.valid <= 1'b0;
    rsp = '0;
    for (int i = 1; i < 500 && rsp.valid !== 1'b1; i++) begin
      #1;
      rsp = host_resp_o;
      lat = i;
      if (rsp.valid !== 1'b1) @(posedge sys_clk_i);
    end
    settle();
    nreq = req_cnt - base;
    check("resp valid", rsp.valid, 1);
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    reg_rd(sgc_pkg::REG_CTRL);
    check("ctrl reset", rd, 32'h0);
    reg_rd(sgc_pkg::REG_SEG_SIZE);
    check("seg size", rd[15:0], 32'hffff);
    reg_wr(sgc_pkg::REG_SEG_SIZE, 32'h100);
    reg_rd(sgc_pkg::REG_STATUS);
    check("fixed err off", rd[sgc_pkg::ST_FIXED_ERR], 32'h0);
    reg_wr(sgc_pkg::REG_CTRL, 32'h8);
    reg_wr(sgc_pkg::REG_SEG_SIZE, 32'h100);
    reg_rd(sgc_pkg::REG_STATUS);
    check("fixed err on", rd[sgc_pkg::ST_FIXED_ERR], 32'h1);
    reg_rd(sgc_pkg::REG_SEG_SIZE);
    check("seg size kept", rd[15:0], 32'hffff);
    reg_wr(sgc_pkg::REG_STATUS, 32'h4);
    reg_wr(sgc_pkg::REG_CTRL, 32'h0);
    reg_wr(sgc_pkg::REG_PF_LIMITS, 32'h0);
    reg_rd(8'h40);
    check("unmapped", rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_read();
    cmd(sgc_pkg::SGC_CMD_READ, 32'h100, 16'h8);
    check("miss", rsp.result, sgc_pkg::SGC_RES_MISS);
    check("miss reqs", nreq, 32'h2);
    cmd(sgc_pkg::SGC_CMD_READ, 32'h100, 16'h8);
    check("hit", rsp.result, sgc_pkg::SGC_RES_CACHE_HIT);
    check("hit reqs", nreq, 32'h0);
    check("hit lat", lat, 32'h2);
    cmd(sgc_pkg::SGC_CMD_READ, 32'h108, 16'h8);
    check("pf hit", rsp.result, sgc_pkg::SGC_RES_PF_HIT);
    reg_wr(sgc_pkg::REG_CTRL, 32'h5);
    cmd(sgc_pkg::SGC_CMD_READ, 32'h100, 16'h8);
    check("nocache", rsp.result, sgc_pkg::SGC_RES_MISS);
    check("nocache reqs", nreq, 32'h1);
    reg_rd(sgc_pkg::REG_HITS);
    check("hit counts", rd, {16'h1, 16'h1});
    reg_wr(sgc_pkg::REG_CTRL, 32'h0);
    $display("t_read done");
  endtask
  task automatic t_write();
    reg_wr(sgc_pkg::REG_CTRL, 32'h2);
    cmd(sgc_pkg::SGC_CMD_WRITE, 32'h100, 16'h8);
    check("early good", {lat[7:0], 7'h0, rsp.good}, {8'h2, 8'h1});
    check("no media", nreq, 32'h0);
    cmd(sgc_pkg::SGC_CMD_READ, 32'h100, 16'h8);
    check("write hit", rsp.result, sgc_pkg::SGC_RES_CACHE_HIT);
    @(posedge sys_clk_i);
    fail <= 1'b1;
    cmd(sgc_pkg::SGC_CMD_SYNC, 32'h0, 16'h0);
    check("sync bad", {rsp.good, nreq > 0}, 2'b01);
    reg_rd(sgc_pkg::REG_STATUS);
    check("deferred", rd[sgc_pkg::ST_DEFERRED], 32'h1);
    fail <= 1'b0;
    reg_wr(sgc_pkg::REG_STATUS, 32'h2);
    cmd(sgc_pkg::SGC_CMD_WRITE, 32'h200, 16'h4);
    cmd(sgc_pkg::SGC_CMD_SYNC, 32'h0, 16'h0);
    check("sync good", rsp.good, 32'h1);
    reg_rd(sgc_pkg::REG_STATUS);
    check("clean", rd[sgc_pkg::ST_DIRTY], 32'h0);
    reg_wr(sgc_pkg::REG_CTRL, 32'h0);
    $display("t_write done");
  endtask
  // ==========
  // main sequence and timeout
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_read();
    t_write();
    give_verdict();
  end
endmodule
bind sgc_cache_ctrl sgc_cache_ctrl_assertions #(.NUM_SEG(NUM_SEG)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .host_req_i(host_req_i), .host_ready_o(host_ready_o),
  .host_resp_o(host_resp_o), .media_req_o(media_req_o));
